/* File: hw/sysset_unit.sv */
/*
  sysset_unit: system-settings command unit with apb register access.
  assumes an upstream parser writes command tokens and arguments over
  apb, and that storage and output regulation act on the pulses it emits.
*/
// The APB register port and the register addresses were left to the implementer.
// What this block does
// - lock-on command disables all keys, enters lockout, shows lockout code
// - bus local-lockout message code 11 hex also enters lockout
// - lockout stays until lock-off command; front panel cannot release it
// - keypad query answers 0 unlocked, 1 locked
// - language query answers SCPI or legacy keyword text
// - language command selects legacy acceptance or strict SCPI
// - language resets to legacy-compatible mode
// - password enable sets state only on matching password
// - password disable clears state only on matching password
// - password query answers 1 enabled, 0 disabled
// - protected commands run only while password state is set
// - factory reset restores stored defaults via reset pulse
// - compatibility options select old bus behaviour or 1997 SCPI
// - clear option chooses full reset or passive device clear
// - line feed option answers empty buffer read with line feed
// - debug option enables diagnostic commands; strict disables them
// - save to cell 41 stores flags, only while password enabled
// - version query answers 1997.0
// - unlocked, any command enters remote; local key returns local
// - wrong password on enable logs error -221, execution error
// - protected command while disabled refused with error -203
module sysset_unit
  import sysset_pkg::*;
#(
  parameter int pass_w = 16
)
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // keypad and display
  output logic                     keys_disabled,
  output logic                     local_key_enabled,
  output logic [15:0]              display_code,
  // configuration flags
  output logic                     legacy_accept,
  output logic                     compat_mode,
  output logic                     clear_resets,
  output logic                     empty_linefeed,
  output logic                     debug_accept,
  // storage and output actions
  output logic                     factory_reset_pulse,
  output logic                     save_cell_pulse,
  output logic                     device_reset_pulse,
  output logic                     exec_error_pulse,
  output logic [15:0]              error_code
);
  import sysset_pkg::*;

  // state
  logic              lockout_q,  lockout_d;
  logic              remote_q,   remote_d;
  logic              pass_en_q,  pass_en_d;
  logic              lang_q,     lang_d;
  logic              compat_q,   compat_d;
  logic              clear_q,    clear_d;
  logic              lf_q,       lf_d;
  logic              debug_q,    debug_d;
  logic [pass_w-1:0] arg_q;
  logic [pass_w-1:0] pin_q;
  logic [31:0]       answer_q,   answer_d;
  logic [15:0]       err_q,      err_d;
  logic              exec_q,     exec_d;
  logic              fact_q,     fact_d;
  logic              save_q,     save_d;
  logic              devrst_q,   devrst_d;
  logic              pready_q;
  logic [31:0]       prdata_q;

  // apb decode
  wire        acc      = psel && penable && !pready_q;
  wire        wr       = acc && pwrite;
  wire        rd       = acc && !pwrite;
  wire        hit_cmd  = paddr == cmd_off;
  wire        hit_arg  = paddr == arg_off;
  wire        hit_pin  = paddr == pin_off;
  wire        mapped   = hit_cmd || hit_arg || hit_pin
                       || paddr == status_off || paddr == answer_off
                       || paddr == error_off;
  wire        go       = wr && hit_cmd;
  wire cmd_t  cmd      = cmd_t'(pwdata[3:0]);
  wire [2:0]  opt      = arg_q[2:0];
  wire        pw_match = arg_q == pin_q;
  wire        host_cmd = go && cmd != bus_message && cmd != local_key
                         && cmd != cmd_none;
  wire [31:0] status_word = {23'h0, remote_q, debug_q, lf_q, clear_q,
                             compat_q, lang_q, pass_en_q, lockout_q};
  wire [31:0] rd_mux =
      paddr == cmd_off    ? 32'h0000_0000 :
      paddr == arg_off    ? {{(32-pass_w){1'b0}}, arg_q} :
      paddr == status_off ? status_word :
      paddr == answer_off ? answer_q :
      paddr == error_off  ? {16'h0000, err_q} :
                            32'h0000_0000;

  always_comb
  begin
    lockout_d = lockout_q;
    remote_d  = remote_q;
    pass_en_d = pass_en_q;
    lang_d    = lang_q;
    compat_d  = compat_q;
    clear_d   = clear_q;
    lf_d      = lf_q;
    debug_d   = debug_q;
    answer_d  = answer_q;
    err_d     = err_q;
    exec_d    = 1'b0;
    fact_d    = 1'b0;
    save_d    = 1'b0;
    devrst_d  = 1'b0;
    if (host_cmd)
      remote_d = 1'b1;
    if (go)
    begin
      case (cmd)
        keypad_lock_cmd:
        begin
          lockout_d = arg_q[0];
        end
        keypad_lock_query:
          answer_d = {31'h0, lockout_q};
        language_cmd:
          lang_d = arg_q[0];
        language_query:
          answer_d = lang_q ? text_legacy : text_scpi;
        password_enable_cmd:
        begin
          if (pw_match)
            pass_en_d = 1'b1;
          else
          begin
            err_d  = err_conflict;
            exec_d = 1'b1;
          end
        end
        password_disable_cmd:
        begin
          if (pw_match)
            pass_en_d = 1'b0;
        end
        password_state_query:
          answer_d = {31'h0, pass_en_q};
        factory_reset_cmd, save_cell_cmd:
        begin
          if (!pass_en_q || (cmd == save_cell_cmd
                             && arg_q[15:0] != protected_cell))
          begin
            if (!pass_en_q)
            begin
              err_d  = err_protected;
              exec_d = 1'b1;
            end
          end
          else if (cmd == factory_reset_cmd)
          begin
            fact_d = 1'b1;
            lang_d = rst_language;
          end
          else
            save_d = 1'b1;
        end
        settings_cmd:
        begin
          case (opt)
            compat_off_option:         compat_d = 1'b0;
            compat_on_option:          compat_d = 1'b1;
            clear_passive_option:      clear_d  = 1'b0;
            clear_resets_option:       clear_d  = 1'b1;
            empty_linefeed_off_option: lf_d     = 1'b0;
            empty_linefeed_on_option:  lf_d     = 1'b1;
            strict_option:             debug_d  = 1'b0;
            debug_enable_option:       debug_d  = 1'b1;
            default:                   compat_d = compat_q;
          endcase
        end
        version_query:
          answer_d = {version_year, version_rev};
        bus_message:
        begin
          if (arg_q[15:0] == llo_code)
            lockout_d = 1'b1;
        end
        local_key:
        begin
          if (!lockout_q)
            remote_d = 1'b0;
        end
        device_clear:
          devrst_d = clear_q;
        default:
          answer_d = answer_q;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      lockout_q <= 1'b0;
      remote_q  <= 1'b0;
      pass_en_q <= 1'b0;
      lang_q    <= rst_language;
      compat_q  <= rst_compat;
      clear_q   <= rst_clear;
      lf_q      <= rst_linefeed;
      debug_q   <= rst_debug;
      arg_q     <= '0;
      pin_q     <= default_password[pass_w-1:0];
      answer_q  <= 32'h0000_0000;
      err_q     <= 16'h0000;
      exec_q    <= 1'b0;
      fact_q    <= 1'b0;
      save_q    <= 1'b0;
      devrst_q  <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      lockout_q <= lockout_d;
      remote_q  <= remote_d;
      pass_en_q <= pass_en_d;
      lang_q    <= lang_d;
      compat_q  <= compat_d;
      clear_q   <= clear_d;
      lf_q      <= lf_d;
      debug_q   <= debug_d;
      answer_q  <= answer_d;
      err_q     <= err_d;
      exec_q    <= exec_d;
      fact_q    <= fact_d;
      save_q    <= save_d;
      devrst_q  <= devrst_d;
      pready_q  <= acc;
      if (wr && hit_arg)
        arg_q <= pwdata[pass_w-1:0];
      if (wr && hit_pin && pass_en_q)
        pin_q <= pwdata[pass_w-1:0];
      if (rd)
        prdata_q <= rd_mux;
    end
  end

  // registered outputs
  logic        keys_off_q, local_en_q;
  logic [15:0] disp_q;
  logic        slverr_q;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      keys_off_q <= 1'b0;
      local_en_q <= 1'b1;
      disp_q     <= local_display_code;
      slverr_q   <= 1'b0;
    end
    else
    begin
      keys_off_q <= lockout_d || remote_d;
      local_en_q <= !lockout_d;
      disp_q     <= lockout_d ? lockout_display_code :
                    remote_d  ? remote_display_code :
                                local_display_code;
      slverr_q   <= acc && !mapped;
    end
  end

  assign pready              = pready_q;
  assign prdata              = prdata_q;
  assign pslverr             = slverr_q;
  assign keys_disabled       = keys_off_q;
  assign local_key_enabled   = local_en_q;
  assign display_code        = disp_q;
  assign legacy_accept       = lang_q;
  assign compat_mode         = compat_q;
  assign clear_resets        = clear_q;
  assign empty_linefeed      = lf_q;
  assign debug_accept        = debug_q;
  assign factory_reset_pulse = fact_q;
  assign save_cell_pulse     = save_q;
  assign device_reset_pulse  = devrst_q;
  assign exec_error_pulse    = exec_q;
  assign error_code          = err_q;

  // assertions
  lock_holds_a: assert property (@(posedge clock) disable iff (reset)
    $fell(lockout_q) |-> $past(go) && $past(cmd) == keypad_lock_cmd
      && !$past(arg_q[0]))
    else $error("lockout released without lock-off");
  lock_disp_a: assert property (@(posedge clock) disable iff (reset)
    lockout_q |-> display_code == lockout_display_code && !local_key_enabled)
    else $error("lockout display or local key wrong");
  llo_enter_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == bus_message && arg_q[15:0] == llo_code |=> lockout_q)
    else $error("llo did not lock");
  local_key_a: assert property (@(posedge clock) disable iff (reset)
    lockout_q && go && cmd == local_key |=> lockout_q)
    else $error("local key released lockout");
  pass_set_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == password_enable_cmd |=> pass_en_q == ($past(pw_match)
      || $past(pass_en_q)))
    else $error("password enable mismatch");
  pass_clr_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == password_disable_cmd && pw_match |=> !pass_en_q)
    else $error("password disable failed");
  bad_pass_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == password_enable_cmd && !pw_match |=>
      exec_error_pulse && error_code == err_conflict)
    else $error("wrong password not flagged");
  protect_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == factory_reset_cmd && !pass_en_q |=>
      !factory_reset_pulse && error_code == err_protected)
    else $error("protected command ran");
  save_a: assert property (@(posedge clock) disable iff (reset)
    save_cell_pulse |-> $past(pass_en_q))
    else $error("save without password");
  version_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == version_query |=> answer_q == 32'h07cd_0000)
    else $error("version answer wrong");
  lang_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == language_cmd |=> legacy_accept == $past(arg_q[0]))
    else $error("language not applied");
  apb_a: assert property (@(posedge clock) disable iff (reset)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  lock_keys_a: assert property (@(posedge clock) disable iff (reset)
    lockout_q |-> keys_disabled)
    else $error("keys live during lockout");
  lock_query_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == keypad_lock_query |=> answer_q == {31'h0, $past(lockout_q)})
    else $error("keypad query answer wrong");
  lang_query_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == language_query |=> answer_q ==
      ($past(lang_q) ? text_legacy : text_scpi))
    else $error("language query answer wrong");
  pass_query_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == password_state_query |=> answer_q == {31'h0,
      $past(pass_en_q)})
    else $error("password query answer wrong");
  factory_a: assert property (@(posedge clock) disable iff (reset)
    factory_reset_pulse |-> $past(pass_en_q) && legacy_accept)
    else $error("factory reset without password or language");
  clear_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == device_clear |=> device_reset_pulse == $past(clear_q))
    else $error("device clear option ignored");
  remote_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == other_cmd |=> keys_disabled)
    else $error("command did not enter remote");
  linefeed_a: assert property (@(posedge clock) disable iff (reset)
    go && cmd == settings_cmd && opt == empty_linefeed_on_option
      |=> empty_linefeed)
    else $error("line feed option not applied");

  lock_c:  cover property (@(posedge clock) $rose(lockout_q));
  reset_c: cover property (@(posedge clock) factory_reset_pulse);
  bad_c:   cover property (@(posedge clock) exec_error_pulse);
  clear_c: cover property (@(posedge clock) device_reset_pulse);
  lang_c:  cover property (@(posedge clock) go && cmd == language_query);

endmodule : sysset_unit

/* File: hw/sysset_pkg.sv */
/*
  sysset_pkg: command codes, register map, option codes, reset values
  and answer constants for the system-settings command unit.
  assumes one 100 MHz clock and an apb master reaching the registers.
*/
package sysset_pkg;

  // register byte offsets
  localparam logic [7:0] cmd_off     = 8'h00;
  localparam logic [7:0] arg_off     = 8'h04;
  localparam logic [7:0] status_off  = 8'h08;
  localparam logic [7:0] answer_off  = 8'h0c;
  localparam logic [7:0] error_off   = 8'h10;
  localparam logic [7:0] pin_off     = 8'h14;

  // command codes written to cmd register
  typedef enum logic [3:0] {
    cmd_none        = 4'b0000,
    keypad_lock_cmd = 4'b0001,
    keypad_lock_query = 4'b0010,
    language_cmd    = 4'b0011,
    language_query  = 4'b0100,
    password_enable_cmd  = 4'b0101,
    password_disable_cmd = 4'b0110,
    password_state_query = 4'b0111,
    factory_reset_cmd = 4'b1000,
    settings_cmd    = 4'b1001,
    save_cell_cmd   = 4'b1010,
    version_query   = 4'b1011,
    other_cmd       = 4'b1100,
    bus_message     = 4'b1101,
    local_key       = 4'b1110,
    device_clear    = 4'b1111
  } cmd_t;

  // settings options (argument of settings_cmd)
  localparam logic [2:0] compat_off_option         = 3'h0;
  localparam logic [2:0] compat_on_option          = 3'h1;
  localparam logic [2:0] clear_passive_option      = 3'h2;
  localparam logic [2:0] clear_resets_option       = 3'h3;
  localparam logic [2:0] empty_linefeed_off_option = 3'h4;
  localparam logic [2:0] empty_linefeed_on_option  = 3'h5;
  localparam logic [2:0] strict_option             = 3'h6;
  localparam logic [2:0] debug_enable_option       = 3'h7;

  // language argument: 0 scpi, 1 legacy
  localparam logic [15:0] llo_code        = 16'h0011;
  localparam logic [15:0] protected_cell  = 16'h0029;
  localparam logic [15:0] default_password = 16'h0000;

  // answers
  localparam logic [31:0] text_scpi    = 32'h5343_5049;
  localparam logic [31:0] text_legacy  = 32'h434f_4d50;
  localparam logic [15:0] version_year = 16'h07cd;
  localparam logic [15:0] version_rev  = 16'h0000;
  localparam logic [15:0] local_display_code   = 16'h4c6f;
  localparam logic [15:0] lockout_display_code = 16'h5277;
  localparam logic [15:0] remote_display_code  = 16'h526d;

  // error codes (negative, sixteen bit two's complement)
  localparam logic [15:0] err_protected = 16'hff35;
  localparam logic [15:0] err_conflict  = 16'hff23;

  // factory defaults: 1.28 % of full scale is 128 / 10000
  localparam logic [15:0] step_current_num = 16'h0080;
  localparam logic [15:0] step_current_den = 16'h2710;
  localparam logic [15:0] prot_percent     = 16'h000a;

  // reset values of the flags
  localparam logic rst_language = 1'b1;
  localparam logic rst_compat   = 1'b0;
  localparam logic rst_clear    = 1'b0;
  localparam logic rst_linefeed = 1'b0;
  localparam logic rst_debug    = 1'b0;

endpackage : sysset_pkg

/* File: tb/apb_host_model.sv */
/*
  apb_host_model: remote host controller side of the settings unit,
  an apb master driving requests on the rising edge.
  assumes one rising-edge clock shared with the unit under test.
*/
module apb_host_model
(
  // clock
  input  wire logic        clock,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released lines stop showing the old request
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host_model

/* File: tb/system_settings_lockout_password_unit_bench.sv */
/*
  bench for sysset_unit: table of commands then hand-written cases.
  assumes the apb host model as far side and one 100 MHz clock.
*/
module system_settings_lockout_password_unit_bench;
  import sysset_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    cmd_t        cmd;
    logic [15:0] arg;
    logic [7:0]  addr;
    logic [31:0] exp;
  } row_t;

  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic keys_disabled, local_key_enabled, legacy_accept, compat_mode;
  logic clear_resets, empty_linefeed, debug_accept, er;
  logic factory_reset_pulse, save_cell_pulse, device_reset_pulse;
  logic exec_error_pulse;
  logic [15:0] display_code, error_code;
  logic [3:0] pulses_q = 4'h0;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  // rows: command, argument, register read back, expected word
  row_t rows [25] = '{
    '{settings_cmd, 16'h0001, status_off, 32'h0000_000c},
    '{settings_cmd, 16'h0000, status_off, 32'h0000_0004},
    '{settings_cmd, 16'h0003, status_off, 32'h0000_0014},
    '{settings_cmd, 16'h0002, status_off, 32'h0000_0004},
    '{settings_cmd, 16'h0005, status_off, 32'h0000_0024},
    '{settings_cmd, 16'h0004, status_off, 32'h0000_0004},
    '{settings_cmd, 16'h0007, status_off, 32'h0000_0044},
    '{settings_cmd, 16'h0006, status_off, 32'h0000_0004},
    '{language_cmd, 16'h0000, status_off, 32'h0000_0000},
    '{language_query, 16'h0000, answer_off, text_scpi},
    '{language_cmd, 16'h0001, status_off, 32'h0000_0004},
    '{language_query, 16'h0000, answer_off, text_legacy},
    '{version_query, 16'h0000, answer_off, 32'h07cd_0000},
    '{password_state_query, 16'h0000, answer_off, 32'h0000_0000},
    '{password_enable_cmd, 16'h0000, status_off, 32'h0000_0006},
    '{password_state_query, 16'h0000, answer_off, 32'h0000_0001},
    '{password_disable_cmd, 16'h0001, status_off, 32'h0000_0006},
    '{password_disable_cmd, 16'h0000, status_off, 32'h0000_0004},
    '{keypad_lock_cmd, 16'h0001, status_off, 32'h0000_0005},
    '{keypad_lock_query, 16'h0000, answer_off, 32'h0000_0001},
    '{local_key, 16'h0000, status_off, 32'h0000_0005},
    '{keypad_lock_cmd, 16'h0000, status_off, 32'h0000_0004},
    '{keypad_lock_query, 16'h0000, answer_off, 32'h0000_0000},
    '{bus_message, llo_code, status_off, 32'h0000_0005},
    '{keypad_lock_cmd, 16'h0000, status_off, 32'h0000_0004}
  };

  always #5 clock = ~clock;

  // pulses as they stand while pready is high
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (pready === 1'b1)
      pulses_q <= {factory_reset_pulse, save_cell_pulse,
                   device_reset_pulse, exec_error_pulse};
    if (cyc == 4000)
    begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  apb_host_model i_host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  sysset_unit i_dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .keys_disabled(keys_disabled), .local_key_enabled(local_key_enabled),
    .display_code(display_code), .legacy_accept(legacy_accept),
    .compat_mode(compat_mode), .clear_resets(clear_resets),
    .empty_linefeed(empty_linefeed), .debug_accept(debug_accept),
    .factory_reset_pulse(factory_reset_pulse),
    .save_cell_pulse(save_cell_pulse),
    .device_reset_pulse(device_reset_pulse),
    .exec_error_pulse(exec_error_pulse), .error_code(error_code));

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // argument first, then the command word
  task automatic exec(cmd_t c, logic [15:0] a);
    i_host.xfer(1'b1, arg_off, {16'h0000, a}, v, er);
    i_host.xfer(1'b1, cmd_off, {28'h000_0000, c}, v, er);
    #1;
  endtask : exec

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("display", {16'h0000, display_code}, {16'h0000, local_display_code});
    chk("legacy", {31'h0000_0000, legacy_accept}, 32'h0000_0001);
    i_host.xfer(1'b0, status_off, 32'h0000_0000, v, er);
    chk("status", v, 32'h0000_0004);
    foreach (rows[i])
    begin
      exec(rows[i].cmd, rows[i].arg);
      i_host.xfer(1'b0, rows[i].addr, 32'h0000_0000, v, er);
      if (rows[i].addr == status_off)
        v = v & 32'h0000_007f;
      chk("row", v, rows[i].exp);
    end
    // remote on any command, local key returns
    exec(local_key, 16'h0000);
    chk("display", {16'h0000, display_code}, {16'h0000, local_display_code});
    exec(other_cmd, 16'h0000);
    chk("display", {16'h0000, display_code}, {16'h0000, remote_display_code});
    chk("keys", {30'h0000_0000, keys_disabled, local_key_enabled},
        32'h0000_0003);
    exec(local_key, 16'h0000);
    chk("keys", {31'h0000_0000, keys_disabled}, 32'h0000_0000);
    // lockout survives the local key
    exec(keypad_lock_cmd, 16'h0001);
    exec(local_key, 16'h0000);
    chk("display", {16'h0000, display_code}, {16'h0000, lockout_display_code});
    chk("keys", {30'h0000_0000, keys_disabled, local_key_enabled},
        32'h0000_0002);
    exec(keypad_lock_cmd, 16'h0000);
    // protected save refused, wrong password refused
    exec(save_cell_cmd, protected_cell);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0001);
    chk("error", {16'h0000, error_code}, {16'h0000, err_protected});
    exec(factory_reset_cmd, 16'h0000);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0001);
    exec(password_enable_cmd, 16'h0005);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0001);
    chk("error", {16'h0000, error_code}, {16'h0000, err_conflict});
    // host enables password before protected commands
    exec(password_enable_cmd, default_password);
    exec(save_cell_cmd, protected_cell);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0004);
    exec(language_cmd, 16'h0000);
    exec(factory_reset_cmd, 16'h0000);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0008);
    chk("legacy", {31'h0000_0000, legacy_accept}, 32'h0000_0001);
    // device clear, passive then resetting
    exec(device_clear, 16'h0000);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0000);
    exec(settings_cmd, {13'h0000, clear_resets_option});
    exec(device_clear, 16'h0000);
    chk("pulses", {28'h000_0000, pulses_q}, 32'h0000_0002);
    // unmapped address
    i_host.xfer(1'b0, 8'h1c, 32'h0000_0000, v, er);
    chk("slverr", {31'h0000_0000, er}, 32'h0000_0001);
    chk("flags", {28'h000_0000, debug_accept, empty_linefeed, clear_resets,
        compat_mode}, 32'h0000_0002);
    // stored password changes only while enabled
    i_host.xfer(1'b1, pin_off, 32'h0000_0005, v, er);
    exec(password_disable_cmd, 16'h0005);
    i_host.xfer(1'b0, status_off, 32'h0000_0000, v, er);
    chk("pin", v & 32'h0000_0002, 32'h0000_0000);
    i_host.xfer(1'b1, pin_off, 32'h0000_0007, v, er);
    exec(password_enable_cmd, 16'h0005);
    i_host.xfer(1'b0, status_off, 32'h0000_0000, v, er);
    chk("pin", v & 32'h0000_0002, 32'h0000_0002);
    // mid-run reset brings back the power-up state
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("keys", {30'h0000_0000, keys_disabled, local_key_enabled},
        32'h0000_0001);
    chk("flags", {27'h000_0000, legacy_accept, debug_accept, empty_linefeed,
        clear_resets, compat_mode}, 32'h0000_0010);
    i_host.xfer(1'b0, status_off, 32'h0000_0000, v, er);
    chk("status", v, 32'h0000_0004);
    finish_test();
  end
endmodule : system_settings_lockout_password_unit_bench
